// File: shared/rcbf_defs.vh
// Constants for the receive channel break filter block
`ifndef RCBF_DEFS_VH
`define RCBF_DEFS_VH
// ==========================================
// Register offsets (byte addresses on the plain port)
`define RCBF_ADDR_W 4
`define RCBF_OFF_MODE_CONFIG 4'h0
`define RCBF_OFF_THRESHOLD 4'h1
`define RCBF_OFF_STATUS 4'h2
`define RCBF_OFF_CHAN_PACK 4'h3
`define RCBF_OFF_CNT1 4'h4
`define RCBF_OFF_CNT2 4'h5
// ==========================================
// Mode configuration field positions
`define RCBF_BIT_BOS 0
`define RCBF_BIT_BOB 1
`define RCBF_BIT_CHAN1_THRESHOLD_BREAK_ENABLE 2
`define RCBF_BIT_CHAN2_THRESHOLD_BREAK_ENABLE 3
`define RCBF_BIT_FPP 4
`define RCBF_BIT_DUP 5
// ==========================================
// Copy control codes for channel 0
`define RCBF_COPY_FILT_A 2'h1
`define RCBF_COPY_FILT_B 2'h2
`define RCBF_COPY_PROMISC 2'h3
// ==========================================
// Page figures
`define RCBF_PAGE_BYTES 13'h1000
`define RCBF_MAX_PAGES_FPP 2'h2
`define RCBF_LEN_W 13
`endif

// File: logic/rcbf_frame_tracker.v
// Per-channel copied-frame counter against the threshold
`timescale 1ns/100ps
`default_nettype none
module rcbf_frame_tracker (
	input wire core_clk,
	input wire rst_n,
	input wire enable,
	input wire frame_copied,
	input wire [7:0] threshold,
	output reg hit,
	output reg [7:0] count
);
	// ==========================================
	// Counting
	// Counter restarts after each threshold breakpoint
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 8'h00;
			hit <= 1'b0;
		end else begin
			hit <= 1'b0;
			if (frame_copied) begin
				if (enable && (count + 8'h01 >= threshold)) begin
					count <= 8'h00;
					hit <= 1'b1;
				end else begin
					count <= count + 8'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: logic/rcbf_top.v
// Receive channel breakpoint, page packing and duplicate filter logic
// Notes for users
// Attention outputs are one-cycle pulses; the sticky
// attention register sits outside this block.
// Mode config and threshold have no reset, so they
// hold X after power-up until software writes them.
// Threshold hits reach the outputs one cycle later
// than service and burst causes, via the tracker.
// Frame lengths above one page spill into exactly
// one extra page; longer frames are not expected.
// The full destination address is not compared; only
// the own-address flag from the matcher is used.
// Both threshold channels share one threshold value,
// so they cannot be tuned apart.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "rcbf_defs.vh"
module rcbf_top (
	input wire core_clk,
	input wire rst_n,
	// Register port
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	// Receive state and frame fields
	input wire receive_stop_attention,
	input wire frame_end,
	input wire frame_valid,
	input wire frame_copy_ok,
	input wire frame_is_mac,
	input wire [1:0] frame_channel,
	input wire [7:0] frame_fc,
	input wire [47:0] frame_da,
	input wire [47:0] frame_sa,
	input wire [31:0] frame_info4,
	input wire frame_da_own,
	input wire [12:0] frame_len,
	// Copy setup and ring events
	input wire [1:0] chan0_copy_control,
	input wire token_received,
	input wire ring_op_change,
	// Results, all registered
	output reg chan0_break_attention,
	output reg chan1_break_attention,
	output reg chan2_break_attention,
	output reg frame_copy,
	output reg page_break,
	output reg [1:0] unit_descriptor_count
);
	// ==========================================
	// Registers
	// Mode config has no reset term so it survives reset
	reg [7:0] receive_mode_config;
	reg [7:0] receive_frame_threshold;
	reg [2:0] per_channel_address_config;
	// Frame history for the filter and burst checks
	reg dup_bit_prev;
	reg force_copy;
	reg [7:0] prev_fc;
	reg [31:0] prev_info;
	reg [47:0] prev_sa;
	reg prev_da_own;
	reg [1:0] prev_channel;
	reg have_prev;
	reg copied_since_opp;
	reg [12:0] page_fill;
	// Tracker results
	wire hit1;
	wire hit2;
	wire [7:0] cnt1;
	wire [7:0] cnt2;
	wire [7:0] sticky_view;

	// Mode bits decoded once
	wire service_opportunity_break_enable = receive_mode_config[`RCBF_BIT_BOS];
	wire chan1_threshold_break_enable = receive_mode_config[`RCBF_BIT_CHAN1_THRESHOLD_BREAK_ENABLE];
	wire chan2_threshold_break_enable = receive_mode_config[`RCBF_BIT_CHAN2_THRESHOLD_BREAK_ENABLE];
	wire one_frame_per_page = receive_mode_config[`RCBF_BIT_FPP];
	wire dup_bit = receive_mode_config[`RCBF_BIT_DUP];

	// ==========================================
	// Register writes
	// Config only accepted while receive stop is up or unchanged value
	always @(posedge core_clk) begin
		if (reg_write && reg_addr == `RCBF_OFF_MODE_CONFIG &&
			(receive_stop_attention || reg_wdata == receive_mode_config)) begin
			receive_mode_config <= reg_wdata;
		end
		// Threshold writes wait for receive stop as well
		if (reg_write && reg_addr == `RCBF_OFF_THRESHOLD && receive_stop_attention) begin
			receive_frame_threshold <= reg_wdata;
		end
	end

	// Per-channel packing re-enable bits, cleared by reset
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			per_channel_address_config <= 3'h0;
		end else if (reg_write && reg_addr == `RCBF_OFF_CHAN_PACK) begin
			per_channel_address_config <= reg_wdata[2:0];
		end
	end

	// ==========================================
	// Frame classification
	// Only a frame that ends valid is considered
	wire new_frame = frame_end && frame_valid;
	wire chan0 = (frame_channel == 2'h0);
	wire filt_code = (chan0_copy_control == `RCBF_COPY_FILT_A) ||
		(chan0_copy_control == `RCBF_COPY_FILT_B);
	wire promisc = (chan0_copy_control == `RCBF_COPY_PROMISC);
	// Filter: channel 0 MAC frames under a filter code
	wire filt_active = chan0 && frame_is_mac && filt_code && dup_bit && !promisc;
	// A repeat matches FC and the first info bytes
	wire is_dup = have_prev && (frame_fc == prev_fc) && (frame_info4 == prev_info);
	wire drop_dup = filt_active && is_dup && !force_copy;
	// Copy unless the filter drops a repeat
	wire copy_now = new_frame && frame_copy_ok && !drop_dup;

	// Burst end detection on copied frames
	// Each cause needs a previous copied frame
	wire chan_change = have_prev && (frame_channel != prev_channel);
	wire da_change = have_prev && prev_da_own && !frame_da_own;
	wire sa_change = have_prev && (frame_sa != prev_sa);
	wire info_change = have_prev && frame_is_mac && (frame_info4 != prev_info);
	wire burst_end = copy_now && (chan_change || da_change || sa_change || info_change);

	// Service opportunity end after copied frames
	wire opp_end = copied_since_opp &&
		(token_received || (new_frame && frame_is_mac) || ring_op_change);

	// ==========================================
	// Previous-frame history and filter edge
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dup_bit_prev <= 1'b0;
			force_copy <= 1'b0;
			prev_fc <= 8'h00;
			prev_info <= 32'h0000_0000;
			prev_sa <= 48'h0000_0000_0000;
			prev_da_own <= 1'b0;
			prev_channel <= 2'h0;
			have_prev <= 1'b0;
			copied_since_opp <= 1'b0;
		end else begin
			// Filter bit delayed one cycle for edge detect
			dup_bit_prev <= dup_bit;
			// Edge arms one forced copy; event in same cycle still arms
			if (dup_bit && !dup_bit_prev) begin
				force_copy <= 1'b1;
			end else if (new_frame && chan0 && frame_is_mac) begin
				force_copy <= 1'b0;
			end
			// History follows copied frames only
			if (copy_now) begin
				prev_fc <= frame_fc;
				prev_info <= frame_info4;
				prev_sa <= frame_sa;
				prev_da_own <= frame_da_own;
				prev_channel <= frame_channel;
				have_prev <= 1'b1;
			end
			// A copy in the same cycle keeps the opportunity open
			if (copy_now) begin
				copied_since_opp <= 1'b1;
			end else if (opp_end) begin
				copied_since_opp <= 1'b0;
			end
		end
	end

	// ==========================================
	// Threshold counters for channels 1 and 2
	// Both channels share the one threshold value
	rcbf_frame_tracker u_trk1 (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.enable(chan1_threshold_break_enable),
		.frame_copied(copy_now && frame_channel == 2'h1),
		.threshold(receive_frame_threshold),
		.hit(hit1),
		.count(cnt1)
	);
	rcbf_frame_tracker u_trk2 (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.enable(chan2_threshold_break_enable),
		.frame_copied(copy_now && frame_channel == 2'h2),
		.threshold(receive_frame_threshold),
		.hit(hit2),
		.count(cnt2)
	);

	// ==========================================
	// Break attention pulses
	// Service and burst causes go to the channel of the last copied frame
	wire [2:0] prev_onehot = 3'h1 << prev_channel;
	// Threshold hits exist only on channels 1 and 2
	wire [2:0] thr_hit = {hit2, hit1, 1'b0};
	wire [2:0] next_attention;
	genvar ch_i;
	generate
		for (ch_i = 0; ch_i < 3; ch_i = ch_i + 1) begin : g_attn
			assign next_attention[ch_i] = (service_opportunity_break_enable && opp_end && prev_onehot[ch_i]) ||
				(burst_end && prev_onehot[ch_i]) || thr_hit[ch_i];
		end
	endgenerate

	// Attention pulses to the attention register outside; one cycle each
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan0_break_attention <= 1'b0;
			chan1_break_attention <= 1'b0;
			chan2_break_attention <= 1'b0;
		end else begin
			chan0_break_attention <= next_attention[0];
			chan1_break_attention <= next_attention[1];
			chan2_break_attention <= next_attention[2];
		end
	end

	// ==========================================
	// Page packing
	// Packing is off under frame per page unless re-enabled
	wire pack_allowed = !one_frame_per_page || per_channel_address_config[frame_channel];
	// Running fill of the open page, one bit wider for overflow
	wire [13:0] fill_sum = {1'b0, page_fill} + {1'b0, frame_len};
	wire fits = fill_sum <= {1'b0, `RCBF_PAGE_BYTES};
	// Break when packing is off, the frame overflows, or no page is open
	wire need_break = !pack_allowed || !fits || page_fill == 13'h0000;
	// A frame longer than a page spills into one more
	wire spans_two = (frame_len > `RCBF_PAGE_BYTES);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_copy <= 1'b0;
			page_break <= 1'b0;
			unit_descriptor_count <= 2'h0;
			page_fill <= 13'h0000;
		end else begin
			// Pulses and unit count follow the copy by a cycle
			frame_copy <= copy_now;
			page_break <= copy_now && need_break;
			if (copy_now) begin
				// Fresh page per frame keeps spill to one extra page
				if (!pack_allowed) begin
					unit_descriptor_count <= spans_two ? `RCBF_MAX_PAGES_FPP : 2'h1;
					page_fill <= 13'h0000;
				end else if (need_break) begin
					unit_descriptor_count <= spans_two ? `RCBF_MAX_PAGES_FPP : 2'h1;
					page_fill <= spans_two ? frame_len - `RCBF_PAGE_BYTES : frame_len;
				end else begin
					unit_descriptor_count <= 2'h1;
					page_fill <= fill_sum[12:0];
				end
			end
		end
	end

	// ==========================================
	// Read port, data one cycle after strobe
	// Status bits expose internal history for software debug
	assign sticky_view = {3'h0, copied_since_opp, force_copy, have_prev, dup_bit_prev, one_frame_per_page};
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			case (reg_addr)
				`RCBF_OFF_MODE_CONFIG: reg_rdata <= receive_mode_config;
				`RCBF_OFF_THRESHOLD: reg_rdata <= receive_frame_threshold;
				`RCBF_OFF_STATUS: reg_rdata <= sticky_view;
				`RCBF_OFF_CHAN_PACK: reg_rdata <= {5'h00, per_channel_address_config};
				`RCBF_OFF_CNT1: reg_rdata <= cnt1;
				`RCBF_OFF_CNT2: reg_rdata <= cnt2;
				// Unmapped offsets read as zero
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			// Read data return to zero outside the answer cycle
			reg_rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// File: testbench/rcbf_top_asserts.sv
// Concurrent checks on the break filter ports
`timescale 1ns/100ps
`default_nettype none
module rcbf_top_chk (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic frame_end,
	input wire logic frame_valid,
	input wire logic frame_copy_ok,
	input wire logic frame_is_mac,
	input wire logic [1:0] frame_channel,
	input wire logic [1:0] chan0_copy_control,
	input wire logic token_received,
	input wire logic ring_op_change,
	input wire logic chan0_break_attention,
	input wire logic chan1_break_attention,
	input wire logic chan2_break_attention,
	input wire logic frame_copy,
	input wire logic page_break,
	input wire logic [1:0] unit_descriptor_count
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// Read, copy and page path
	rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	copy_cause_a: assert property (frame_copy |-> $past(frame_end && frame_valid && frame_copy_ok))
		else $error("copy without frame");
	promisc_copy_a: assert property (frame_end && frame_valid && frame_copy_ok && frame_is_mac
		&& frame_channel == 2'h0 && chan0_copy_control == 2'h3 |=> frame_copy) else $error("promiscuous frame dropped");
	page_copy_a: assert property (page_break |-> frame_copy)
		else $error("page without copy");
	udc_hold_a: assert property (!frame_copy |-> $stable(unit_descriptor_count))
		else $error("unit count moved");
	// ==========
	// Attention causes
	ch0_cause_a: assert property (chan0_break_attention |-> $past(frame_end || token_received || ring_op_change))
		else $error("stray channel 0 attention");
	ch1_cause_a: assert property (chan1_break_attention |-> $past(frame_end || token_received || ring_op_change)
		|| $past(frame_end, 2)) else $error("stray channel 1 attention");
	ch2_cause_a: assert property (chan2_break_attention |-> $past(frame_end || token_received || ring_op_change)
		|| $past(frame_end, 2)) else $error("stray channel 2 attention");
endmodule
bind rcbf_top rcbf_top_chk u_chk (.*);
`default_nettype wire

// File: testbench/rcbf_ring_src.sv
// Ring receive path model: frame ends and token events
`timescale 1ns/100ps
`default_nettype none
module rcbf_ring_src (
	input wire logic core_clk,
	output logic frame_end,
	output logic frame_is_mac,
	output logic [1:0] frame_channel,
	output logic [7:0] frame_fc,
	output logic [47:0] frame_sa,
	output logic [31:0] frame_info4,
	output logic [12:0] frame_len,
	output logic token_received,
	output logic ring_op_change
);
	initial {frame_end, frame_is_mac, frame_channel, frame_fc, frame_sa, frame_info4, frame_len} = '0;
	initial {token_received, ring_op_change} = '0;
	// One frame end; FC, SA and info turn over after so stale values are never reused
	task automatic send(input logic [1:0] c, input logic m, input logic [7:0] f, input logic [47:0] s,
		input logic [31:0] i, input logic [12:0] l);
		@(posedge core_clk);
		{frame_end, frame_is_mac, frame_channel, frame_fc, frame_sa, frame_info4, frame_len} <= {1'b1, m, c, f, s, i, l};
		@(posedge core_clk);
		{frame_end, frame_fc, frame_sa, frame_info4} <= {1'b0, ~f, ~s, ~i};
		repeat (3) @(posedge core_clk);
	endtask
	// Token or ring change pulse, gap left for the answer
	task automatic event_pulse(input logic tok);
		@(posedge core_clk);
		{token_received, ring_op_change} <= {tok, !tok};
		@(posedge core_clk);
		{token_received, ring_op_change} <= 2'h0;
		repeat (3) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// File: testbench/rcbf_top_test.sv
// Self-checking bench for the receive channel break filter
`timescale 1ns/100ps
`default_nettype none
module rcbf_top_test;
	logic core_clk, rst_n, reg_write, reg_read, stop, own, ok;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [1:0] cc;
	wire [7:0] rdata, fc;
	wire a0, a1, a2, cp, pb, fe, mac, tok, ring;
	wire [1:0] udc, ch;
	wire [47:0] sa;
	wire [31:0] info;
	wire [12:0] len;
	int n_errors, n_tests, c1, c2, ncp, npb;
	rcbf_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata), .receive_stop_attention(stop),
		.frame_end(fe), .frame_valid(1'b1), .frame_copy_ok(ok), .frame_is_mac(mac), .frame_channel(ch),
		.frame_fc(fc), .frame_da(48'h0), .frame_sa(sa), .frame_info4(info), .frame_da_own(own),
		.frame_len(len), .chan0_copy_control(cc), .token_received(tok), .ring_op_change(ring),
		.chan0_break_attention(a0), .chan1_break_attention(a1), .chan2_break_attention(a2),
		.frame_copy(cp), .page_break(pb), .unit_descriptor_count(udc));
	rcbf_ring_src u_src (.core_clk(core_clk), .frame_end(fe), .frame_is_mac(mac), .frame_channel(ch),
		.frame_fc(fc), .frame_sa(sa), .frame_info4(info), .frame_len(len), .token_received(tok),
		.ring_op_change(ring));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// Pulse tallies on the falling edge, where outputs have settled
	always @(negedge core_clk) begin
		c1 += a1;
		c2 += a2;
		ncp += cp;
		npb += pb;
	end
	task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		{reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		{reg_addr, reg_read} <= {a, 1'b1};
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1;
		chk("reg read", rdata, e);
	endtask
	task automatic fr(input logic [1:0] c, input logic [31:0] i, input logic [47:0] s, input logic [12:0] l);
		u_src.send(c, c == 2'h0, 8'hC2, s, i, l);
	endtask
	task automatic d0(input logic [31:0] i, input logic [7:0] e);
		ncp = 0;
		fr(2'h0, i, 48'h1, 13'h40);
		chk("chan0 copy", ncp[7:0], e);
	endtask
	task automatic test_done;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		{rst_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
		stop = 1'b1;
		own = 1'b1;
		ok = 1'b1;
		cc = 2'h1;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		// Config survives reset; writes refused outside receive stop
		wr(4'h0, 8'h2C);
		wr(4'h1, 8'h03);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rc(4'h0, 8'h2C);
		stop <= 1'b0;
		wr(4'h0, 8'h00);
		rc(4'h0, 8'h2C);
		rc(4'h1, 8'h03);
		rc(4'hF, 8'h00);
		stop <= 1'b1;
		$display("regs done");
		// Duplicate filter on channel 0
		wr(4'h0, 8'h00);
		d0(32'h5, 8'h01);
		d0(32'h5, 8'h01);
		wr(4'h0, 8'h20);
		d0(32'h5, 8'h01);
		d0(32'h5, 8'h00);
		d0(32'h6, 8'h01);
		cc <= 2'h3;
		d0(32'h6, 8'h01);
		cc <= 2'h2;
		d0(32'h6, 8'h00);
		ok <= 1'b0;
		d0(32'h7, 8'h00);
		ok <= 1'b1;
		$display("dup done");
		// Threshold of three on channel 1, then a source change and a destination change
		wr(4'h0, 8'h04);
		c1 = 0;
		repeat (6) fr(2'h1, 32'h0, 48'h1, 13'h40);
		chk("threshold", c1[7:0], 8'h02);
		c1 = 0;
		fr(2'h1, 32'h0, 48'h2, 13'h40);
		chk("sa burst", c1[7:0], 8'h01);
		own <= 1'b0;
		c1 = 0;
		fr(2'h1, 32'h0, 48'h2, 13'h40);
		chk("da burst", c1[7:0], 8'h01);
		own <= 1'b1;
		$display("thresh done");
		// Service opportunity ends on token only after copies
		wr(4'h0, 8'h01);
		fr(2'h2, 32'h0, 48'h2, 13'h40);
		c2 = 0;
		u_src.event_pulse(1'b1);
		chk("opp token", c2[7:0], 8'h01);
		u_src.event_pulse(1'b0);
		chk("opp idle", c2[7:0], 8'h01);
		rc(4'h5, 8'h01);
		$display("opp done");
		// Page use with and without one frame per page
		wr(4'h0, 8'h10);
		npb = 0;
		repeat (2) fr(2'h1, 32'h0, 48'h2, 13'h40);
		chk("fpp pages", npb[7:0], 8'h02);
		chk("one unit", {6'h0, udc}, 8'h01);
		fr(2'h1, 32'h0, 48'h2, 13'h1400);
		chk("two units", {6'h0, udc}, 8'h02);
		wr(4'h3, 8'h02);
		fr(2'h1, 32'h0, 48'h2, 13'h40);
		npb = 0;
		fr(2'h1, 32'h0, 48'h2, 13'h40);
		chk("repack", npb[7:0], 8'h00);
		wr(4'h3, 8'h00);
		wr(4'h0, 8'h00);
		fr(2'h1, 32'h0, 48'h2, 13'h40);
		npb = 0;
		repeat (2) fr(2'h1, 32'h0, 48'h2, 13'h40);
		chk("packed", npb[7:0], 8'h00);
		$display("pages done");
		test_done;
	end
	// Whole run is well under a thousand cycles
	initial begin
		#200000;
		n_errors++;
		test_done;
	end
endmodule
`default_nettype wire
